// file: can_host_core.sv
// host-side register file, queues, transmit arbitration and interrupt of the can controller
`timescale 1ns/1ps
`default_nettype none
`include "can_host_params.svh"

// What this block does
// (RULE1) loopback_select alone gives loopback, sleep alone sleep, neither normal.
// (RULE2) filter pair: clear enable, wait busy low, write mask, identifier, re-enable.
// (RULE3) software writes interrupt_enable_reg before enabling the controller.
// (RULE4) software writes controller_enable one once configuration is complete.
// (RULE5) a full priority_buffer is transmitted before any queued message.
// (RULE6) tx_done_flag is set for every successfully transmitted message.
// (RULE7) software queues a message as identifier, length, word one, word two.
// (RULE8) queue becoming full sets tx_queue_full_flag in status and interrupt status.
// (RULE9) priority_buffer is loaded only when empty, identifier through word two; only word two is gated, the earlier words are written even when full.
// (RULE10) a write into the priority_buffer sets priority_buffer_full_flag in both registers.
// (RULE11) storing a received message sets rx_not_empty_flag and rx_done_flag.
// (RULE12) reading the receive queue while empty sets rx_underflow_flag.
// (RULE13) software reads all four receive words in order for every message.
// (RULE14) after a message is read, rx_not_empty_flag is set again if more remain.
// (RULE15) the receive line passes one flip-flop that starts at one.
// (RULE16) protocol clock 8 to 24 MHz, host clock 8 to 100 MHz, any relation.
// (RULE17) soft_reset_bit resets the core, itself included, but not the filter pairs.
// (RULE18) under system reset registers take defaults and no access is answered.
// (RULE19) neither reset clears the filter mask and identifier contents.
// (RULE20) reset reaches the core through a synchroniser, some cycles late.
// (RULE21) interrupt_line signals by going high and is low from power-on.
// (RULE22) status bits ignore enables; a one in interrupt_clear_reg clears the bit.
// (RULE23) interrupt_line rises when any status bit and its enable are both one.
// (RULE24) clearing drops the line; on coincidence it drops first, then rises again.
// (RULE25) the receive queue advances only after its fourth word is read.
// (RULE26) with controller_enable zero nothing is sent or received.
module can_host_core (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire can_pkg::reg_req_t reg_req_i,
    output logic [31:0] reg_rdata_o,
    output logic reg_ack_o,
    input wire logic can_rx_i,
    output var can_pkg::msg_t tx_frame_o,
    output logic tx_frame_valid_o,
    input wire logic tx_frame_done_i,
    input wire can_pkg::msg_t rx_frame_i,
    input wire logic rx_frame_valid_i,
    output logic rx_frame_ready_o,
    output logic interrupt_line_o
);
    localparam int QCW = `QUEUE_CNT_W;
    localparam int NF = `NUM_FILTERS;

    // reset synchroniser and core reset
    logic rst_meta_q;
    logic rst_sync_q;
    logic soft_rst_q;
    logic core_rst;

    always_ff @(posedge core_clk_i) begin
        rst_meta_q <= rst_i; // RULE20
        rst_sync_q <= rst_meta_q; // RULE20
    end

    assign core_rst = rst_sync_q | soft_rst_q; // RULE17

    // register access strobes
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;

    assign addr = reg_req_i.addr;
    assign wdata = reg_req_i.wdata;
    assign wr = reg_req_i.req & reg_req_i.we & ~core_rst; // RULE18
    assign rd = reg_req_i.req & ~reg_req_i.we & ~core_rst; // RULE18

    // configuration registers
    logic ctrl_en_q;
    logic sleep_q;
    logic loopback_q;
    logic [`ISR_W-1:0] ier_q;
    logic [`ISR_W-1:0] ier_d;
    logic [NF-1:0] filt_en_q;
    logic [1:0] filt_busy_q;

    always_ff @(posedge core_clk_i) begin
        if (core_rst) begin
            soft_rst_q <= 1'b0; // RULE17
            ctrl_en_q <= 1'b0;
        end else if (wr && addr == `OFS_SOFT_RESET) begin
            soft_rst_q <= wdata[`SRR_SOFT_RESET]; // RULE17
            ctrl_en_q <= wdata[`SRR_ENABLE]; // RULE4
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (core_rst) begin
            sleep_q <= 1'b0;
            loopback_q <= 1'b0;
        end else if (wr && addr == `OFS_MODE) begin
            sleep_q <= wdata[`MSR_SLEEP] & ~wdata[`MSR_LOOPBACK]; // RULE1
            loopback_q <= wdata[`MSR_LOOPBACK] & ~wdata[`MSR_SLEEP]; // RULE1
        end
    end

    always_comb begin
        ier_d = ier_q;
        if (wr && addr == `OFS_IER) begin
            ier_d = wdata[`ISR_W-1:0]; // RULE3
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (core_rst) begin
            ier_q <= '0;
        end else begin
            ier_q <= ier_d;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (core_rst) begin
            filt_en_q <= '0;
            filt_busy_q <= 2'h0;
        end else if (wr && addr == `OFS_FILT_EN) begin
            filt_en_q <= wdata[NF-1:0];
            filt_busy_q <= `FILTER_BUSY_CYCLES; // RULE2
        end else if (filt_busy_q != 2'h0) begin
            filt_busy_q <= filt_busy_q - 2'h1;
        end
    end

    // filter pairs, kept through every reset
    logic [31:0] fmask_q [NF];
    logic [31:0] fid_q [NF];
    logic [NF-1:0] filt_hit;
    logic [31:0] fr_rdata;
    logic [31:0] cand_id;
    logic accept;

    generate
        for (genvar k = 0; k < NF; k++) begin : g_filter
            always_ff @(posedge core_clk_i) begin
                if (wr && addr == `OFS_FILT_BASE + 8'(8 * k)) begin
                    fmask_q[k] <= wdata; // RULE19
                end
                if (wr && addr == `OFS_FILT_BASE + 8'(8 * k + 4)) begin
                    fid_q[k] <= wdata; // RULE19
                end
            end
            assign filt_hit[k] = filt_en_q[k] & (((cand_id ^ fid_q[k]) & fmask_q[k]) == '0);
        end
    endgenerate

    assign accept = (filt_en_q == '0) | (|filt_hit);

    always_comb begin
        fr_rdata = 32'h0000_0000;
        for (int k = 0; k < NF; k++) begin
            if (addr == `OFS_FILT_BASE + 8'(8 * k)) begin
                fr_rdata = fmask_q[k];
            end
            if (addr == `OFS_FILT_BASE + 8'(8 * k + 4)) begin
                fr_rdata = fid_q[k];
            end
        end
    end

    // receive line register
    logic rx_line_q;

    always_ff @(posedge core_clk_i) begin
        if (core_rst) begin
            rx_line_q <= 1'b1; // RULE15
        end else begin
            rx_line_q <= can_rx_i; // RULE15
        end
    end

    // transmit queue staging and priority buffer
    logic [31:0] stage_id_q;
    logic [31:0] stage_dlc_q;
    logic [31:0] stage_dw1_q;
    can_pkg::msg_t pb_q;
    logic pb_full_q;
    logic pb_load;
    logic txq_push;
    logic txq_ready;
    logic txq_valid;
    logic txq_pop;
    logic txq_full_prev_q;
    can_pkg::msg_t txq_head;
    can_pkg::msg_t txq_in;

    always_ff @(posedge core_clk_i) begin
        if (wr && addr == `OFS_TXQ_ID) stage_id_q <= wdata; // RULE7
        if (wr && addr == `OFS_TXQ_DLC) stage_dlc_q <= wdata; // RULE7
        if (wr && addr == `OFS_TXQ_DW1) stage_dw1_q <= wdata; // RULE7
        if (wr && addr == `OFS_PB_ID) pb_q.id <= wdata; // RULE9
        if (wr && addr == `OFS_PB_DLC) pb_q.dlc <= wdata; // RULE9
        if (wr && addr == `OFS_PB_DW1) pb_q.dw1 <= wdata; // RULE9
        if (pb_load) pb_q.dw2 <= wdata; // RULE9
    end

    assign txq_in = '{id: stage_id_q, dlc: stage_dlc_q, dw1: stage_dw1_q, dw2: wdata};
    assign txq_push = wr && addr == `OFS_TXQ_DW2; // RULE7
    assign pb_load = wr && addr == `OFS_PB_DW2 && !pb_full_q; // RULE9

    msg_queue #(
        .WIDTH($bits(can_pkg::msg_t)),
        .DEPTH(`QUEUE_DEPTH),
        .CNT_W(QCW)
    ) u_tx_queue (
        .core_clk_i(core_clk_i),
        .rst_i(core_rst),
        .in_valid_i(txq_push),
        .in_data_i(txq_in),
        .in_ready_o(txq_ready),
        .out_valid_o(txq_valid),
        .out_ready_i(txq_pop),
        .out_data_o(txq_head),
        .count_o()
    );

    // transmit engine
    can_pkg::tx_state_t tx_state_q;
    can_pkg::msg_t cur_q;
    logic from_pb_q;
    logic tx_valid_q;
    logic tx_start;
    logic tx_fin;

    assign tx_start = tx_state_q == can_pkg::TX_IDLE && ctrl_en_q && !sleep_q && rx_line_q
        && (pb_full_q || txq_valid); // RULE26
    assign tx_fin = tx_state_q == can_pkg::TX_SEND && ctrl_en_q
        && (loopback_q || tx_frame_done_i);
    assign txq_pop = tx_fin && !from_pb_q;

    always_ff @(posedge core_clk_i) begin
        if (core_rst) begin
            tx_state_q <= can_pkg::TX_IDLE;
            cur_q <= '0;
            from_pb_q <= 1'b0;
            tx_valid_q <= 1'b0;
        end else begin
            case (tx_state_q)
                can_pkg::TX_IDLE: begin
                    if (tx_start) begin
                        cur_q <= pb_full_q ? pb_q : txq_head; // RULE5
                        from_pb_q <= pb_full_q; // RULE5
                        tx_valid_q <= !loopback_q;
                        tx_state_q <= can_pkg::TX_SEND;
                    end
                end
                can_pkg::TX_SEND: begin
                    if (tx_fin || !ctrl_en_q) begin
                        tx_valid_q <= 1'b0; // RULE26
                        tx_state_q <= can_pkg::TX_IDLE;
                    end
                end
                default: begin
                    tx_state_q <= can_pkg::TX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (core_rst) begin
            pb_full_q <= 1'b0;
        end else if (pb_load) begin
            pb_full_q <= 1'b1; // RULE10
        end else if (tx_fin && from_pb_q) begin
            pb_full_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (core_rst) begin
            txq_full_prev_q <= 1'b0;
        end else begin
            txq_full_prev_q <= !txq_ready;
        end
    end

    assign tx_frame_o = cur_q;
    assign tx_frame_valid_o = tx_valid_q;

    // receive path
    can_pkg::msg_t rx_in;
    can_pkg::msg_t rxq_head;
    logic rx_offer;
    logic rx_store;
    logic rxq_ready;
    logic rxq_valid;
    logic [QCW-1:0] rxq_count;
    logic rx_rd;
    logic rx_pop;

    assign rx_in = loopback_q ? cur_q : rx_frame_i;
    assign cand_id = rx_in.id;
    assign rx_offer = ctrl_en_q && accept
        && (loopback_q ? tx_fin : (rx_frame_valid_i && !sleep_q)); // RULE26
    assign rx_store = rx_offer && rxq_ready;
    assign rx_rd = rd && addr >= `OFS_RXQ_ID && addr <= `OFS_RXQ_DW2 && addr[1:0] == 2'h0;
    assign rx_pop = rd && addr == `OFS_RXQ_DW2 && rxq_valid; // RULE25

    msg_queue #(
        .WIDTH($bits(can_pkg::msg_t)),
        .DEPTH(`QUEUE_DEPTH),
        .CNT_W(QCW)
    ) u_rx_queue (
        .core_clk_i(core_clk_i),
        .rst_i(core_rst),
        .in_valid_i(rx_offer),
        .in_data_i(rx_in),
        .in_ready_o(rxq_ready),
        .out_valid_o(rxq_valid),
        .out_ready_i(rx_pop),
        .out_data_o(rxq_head),
        .count_o(rxq_count)
    );

    assign rx_frame_ready_o = rxq_ready;

    // interrupt status, enable and line
    logic [`ISR_W-1:0] isr_q;
    logic [`ISR_W-1:0] isr_set;
    logic [`ISR_W-1:0] isr_clr;
    logic [`ISR_W-1:0] isr_d;
    logic drop;
    logic irq_q;

    always_comb begin
        isr_set = '0;
        isr_set[`ISR_TX_DONE] = tx_fin; // RULE6
        isr_set[`ISR_TXQ_FULL] = !txq_ready && !txq_full_prev_q; // RULE8
        isr_set[`ISR_PB_FULL] = pb_load; // RULE10
        isr_set[`ISR_RX_DONE] = rx_store; // RULE11
        isr_set[`ISR_RX_NOT_EMPTY] = rx_store || (rx_pop && rxq_count > QCW'(1)); // RULE14
        isr_set[`ISR_RX_UNDERFLOW] = rx_rd && !rxq_valid; // RULE12
        isr_clr = (wr && addr == `OFS_ICR) ? wdata[`ISR_W-1:0] : '0; // RULE22
        isr_d = (isr_q & ~isr_clr) | isr_set;
        drop = |(isr_clr & isr_q & ier_q) | |(ier_q & ~ier_d & isr_q); // RULE24
    end

    always_ff @(posedge core_clk_i) begin
        if (core_rst) begin
            isr_q <= '0;
            irq_q <= 1'b0; // RULE21
        end else begin
            isr_q <= isr_d; // RULE22
            irq_q <= !drop && |(isr_d & ier_d); // RULE23
        end
    end

    assign interrupt_line_o = irq_q;

    // read mux and answer
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    logic ack_q;

    always_comb begin
        rdata_d = 32'h0000_0000;
        case (addr)
            `OFS_SOFT_RESET: rdata_d[`SRR_ENABLE] = ctrl_en_q;
            `OFS_MODE: begin
                rdata_d[`MSR_SLEEP] = sleep_q;
                rdata_d[`MSR_LOOPBACK] = loopback_q;
            end
            `OFS_STATUS: begin
                rdata_d[`SR_FILTER_BUSY] = filt_busy_q != 2'h0; // RULE2
                rdata_d[`SR_TXQ_FULL] = !txq_ready; // RULE8
                rdata_d[`SR_PB_FULL] = pb_full_q; // RULE10
                rdata_d[`SR_LOOPBACK] = loopback_q;
                rdata_d[`SR_SLEEP] = sleep_q;
                rdata_d[`SR_RX_LINE] = rx_line_q;
            end
            `OFS_ISR: rdata_d[`ISR_W-1:0] = isr_q;
            `OFS_IER: rdata_d[`ISR_W-1:0] = ier_q;
            `OFS_FILT_EN: rdata_d[NF-1:0] = filt_en_q;
            `OFS_RXQ_ID: rdata_d = rxq_head.id; // RULE13
            `OFS_RXQ_DLC: rdata_d = rxq_head.dlc; // RULE13
            `OFS_RXQ_DW1: rdata_d = rxq_head.dw1; // RULE13
            `OFS_RXQ_DW2: rdata_d = rxq_head.dw2; // RULE13
            default: rdata_d = fr_rdata;
        endcase
        if (!rxq_valid && rx_rd) begin
            rdata_d = 32'h0000_0000;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_sync_q) begin
            ack_q <= 1'b0; // RULE18
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= (rd || wr) && !soft_rst_q;
            rdata_q <= rd ? rdata_d : 32'h0000_0000;
        end
    end

    assign reg_ack_o = ack_q;
    assign reg_rdata_o = rdata_q;

    // checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (core_rst);

    a_prio_goes_first: assert property (tx_start && pb_full_q |=> from_pb_q && cur_q == $past(pb_q)) // RULE5
        else $error("queued message sent ahead of priority buffer");
    a_tx_done_flag: assert property (tx_fin |=> isr_q[`ISR_TX_DONE]) // RULE6
        else $error("tx done flag not set");
    a_txq_full_flag: assert property ($fell(txq_ready) |=> isr_q[`ISR_TXQ_FULL]) // RULE8
        else $error("queue full flag missing");
    a_pb_full_flag: assert property (pb_load |=> pb_full_q && isr_q[`ISR_PB_FULL]) // RULE10
        else $error("priority buffer full flags not set");
    a_rx_store_flags: assert property (rx_store |=> isr_q[`ISR_RX_DONE] && isr_q[`ISR_RX_NOT_EMPTY]) // RULE11
        else $error("receive flags not set on store");
    a_rx_underflow: assert property (rx_rd && !rxq_valid |=> isr_q[`ISR_RX_UNDERFLOW]) // RULE12
        else $error("underflow flag not set");
    a_rx_advance_last: assert property (rx_rd && addr != `OFS_RXQ_DW2 && !rx_store |=> $stable(rxq_count)) // RULE25
        else $error("receive queue moved before fourth word");
    a_disabled_quiet: assert property (!ctrl_en_q |=> !tx_frame_valid_o && !$past(rx_store)) // RULE26
        else $error("traffic while controller disabled");
    a_irq_raise: assert property ($rose(|(isr_q & ier_q)) |-> interrupt_line_o) // RULE23
        else $error("interrupt line not raised");
    a_irq_drop_first: assert property (drop |=> !interrupt_line_o) // RULE24
        else $error("interrupt line not dropped");

endmodule : can_host_core

`default_nettype wire

// file: can_host_core_bench.sv
// self-checking bench of the can host-side core
`timescale 1ns/1ps
`default_nettype none
`include "can_host_params.svh"
module can_host_core_bench;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic can_rx = 1'b1;
    can_pkg::reg_req_t req = '0;
    logic [31:0] rdata;
    logic [31:0] v;
    logic ack, tx_valid, tx_done, rx_valid, rx_ready, irq;
    can_pkg::msg_t tx_frame, rx_frame, m;
    can_pkg::msg_t exp[$];
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    always #2.5 core_clk_i = ~core_clk_i;
    can_host_core dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_req_i(req),
        .reg_rdata_o(rdata), .reg_ack_o(ack), .can_rx_i(can_rx), .tx_frame_o(tx_frame),
        .tx_frame_valid_o(tx_valid), .tx_frame_done_i(tx_done), .rx_frame_i(rx_frame),
        .rx_frame_valid_i(rx_valid), .rx_frame_ready_o(rx_ready), .interrupt_line_o(irq));
    can_net_model net (.core_clk_i(core_clk_i), .tx_frame_i(tx_frame), .tx_valid_i(tx_valid),
        .tx_done_o(tx_done), .rx_frame_o(rx_frame), .rx_valid_o(rx_valid),
        .rx_ready_i(rx_ready));
    task automatic test_done;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : test_done
    task automatic chk(input logic [127:0] got, input logic [127:0] want);
        checks_done++;
        if (got !== want) begin
            num_errors++;
            $display("BAD t=%0t got=%h want=%h", $time, got, want);
        end
    endtask : chk
    // one register access; ack and read data are taken in the cycle after the request
    task automatic acc(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(negedge core_clk_i);
        req = '{1'b1, we, a, d};
        @(negedge core_clk_i);
        chk(ack, 1'b1);
        v = rdata;
        req.req = 1'b0;
    endtask : acc
    task automatic put(input logic [7:0] base, input can_pkg::msg_t x);
        for (int i = 0; i < 4; i++) acc(1'b1, base + 8'(4 * i), x[127 - 32 * i -: 32]);
    endtask : put
    task automatic get(output can_pkg::msg_t x);
        for (int i = 0; i < 4; i++) begin
            acc(1'b0, `OFS_RXQ_ID + 8'(4 * i), '0);
            x[127 - 32 * i -: 32] = v;
        end
    endtask : get
    function automatic can_pkg::msg_t rnd_msg();
        return {$urandom, $urandom, $urandom, $urandom};
    endfunction : rnd_msg
    function automatic logic [31:0] bit_of(input int n);
        return 32'h1 << n;
    endfunction : bit_of
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            test_done();
        end
    end
    initial begin
        void'($urandom(32'hc5a10afd));
        repeat (2) @(posedge core_clk_i);
        @(negedge core_clk_i);
        rst_i = 1'b0;
        repeat (3) @(negedge core_clk_i);
        acc(1'b0, `OFS_ISR, '0);
        chk(v, '0);
        chk(irq, 1'b0);
        acc(1'b0, 8'hfc, '0);
        chk(v, '0);
        acc(1'b1, `OFS_MODE, '0);
        acc(1'b1, `OFS_IER, 32'h3f);
        for (int k = 0; k <= `QUEUE_DEPTH; k++) begin
            acc(1'b0, `OFS_STATUS, '0);
            chk(v[`SR_TXQ_FULL], k == `QUEUE_DEPTH);
            m = rnd_msg();
            put(`OFS_TXQ_ID, m);
            if (k < `QUEUE_DEPTH) exp.push_back(m);
        end
        acc(1'b0, `OFS_ISR, '0);
        chk(v & bit_of(`ISR_TXQ_FULL), bit_of(`ISR_TXQ_FULL));
        m = rnd_msg();
        put(`OFS_PB_ID, m);
        exp.push_front(m);
        acc(1'b0, `OFS_STATUS, '0);
        chk(v[`SR_PB_FULL], 1'b1);
        acc(1'b0, `OFS_ISR, '0);
        chk(v & bit_of(`ISR_PB_FULL), bit_of(`ISR_PB_FULL));
        chk(tx_valid, 1'b0);
        acc(1'b1, `OFS_SOFT_RESET, bit_of(`SRR_ENABLE));
        while (net.sent.size() < exp.size()) @(negedge core_clk_i);
        foreach (exp[i]) chk(net.sent[i], exp[i]);
        acc(1'b0, `OFS_ISR, '0);
        chk(v & bit_of(`ISR_TX_DONE), bit_of(`ISR_TX_DONE));
        acc(1'b1, `OFS_ICR, 32'h3f);
        acc(1'b0, `OFS_ISR, '0);
        chk(v, '0);
        repeat (2) @(negedge core_clk_i);
        chk(irq, 1'b0);
        exp.delete();
        for (int k = 0; k < 3; k++) begin
            exp.push_back(rnd_msg());
            net.send(exp[k]);
        end
        acc(1'b0, `OFS_ISR, '0);
        chk(v & 32'h18, 32'h18);
        acc(1'b1, `OFS_ICR, bit_of(`ISR_RX_NOT_EMPTY));
        acc(1'b0, `OFS_RXQ_ID, '0);
        acc(1'b0, `OFS_RXQ_ID, '0);
        chk(v, exp[0][127:96]);
        foreach (exp[i]) begin
            get(m);
            chk(m, exp[i]);
            acc(1'b0, `OFS_ISR, '0);
            chk(v[`ISR_RX_NOT_EMPTY], i < 2);
            acc(1'b1, `OFS_ICR, bit_of(`ISR_RX_NOT_EMPTY));
        end
        acc(1'b1, `OFS_IER, bit_of(`ISR_RX_UNDERFLOW));
        acc(1'b0, `OFS_RXQ_ID, '0);
        chk(v, '0);
        repeat (2) @(negedge core_clk_i);
        chk(irq, 1'b1);
        acc(1'b1, `OFS_ICR, bit_of(`ISR_RX_UNDERFLOW));
        repeat (2) @(negedge core_clk_i);
        chk(irq, 1'b0);
        acc(1'b1, `OFS_SOFT_RESET, '0);
        acc(1'b1, `OFS_MODE, bit_of(`MSR_LOOPBACK));
        acc(1'b1, `OFS_SOFT_RESET, bit_of(`SRR_ENABLE));
        m = rnd_msg();
        put(`OFS_PB_ID, m);
        repeat (4) @(negedge core_clk_i);
        get(exp[0]);
        chk(exp[0], m);
        chk(net.sent.size(), 17);
        acc(1'b1, `OFS_SOFT_RESET, bit_of(`SRR_SOFT_RESET));
        repeat (2) @(negedge core_clk_i);
        acc(1'b0, `OFS_SOFT_RESET, '0);
        chk(v, '0);
        acc(1'b0, `OFS_MODE, '0);
        chk(v, '0);
        acc(1'b1, `OFS_FILT_EN, '0);
        acc(1'b0, `OFS_STATUS, '0);
        chk(v[`SR_FILTER_BUSY], 1'b1);
        acc(1'b0, `OFS_STATUS, '0);
        chk(v[`SR_FILTER_BUSY], 1'b0);
        m = rnd_msg();
        acc(1'b1, `OFS_FILT_BASE, 32'hffff_ffff);
        acc(1'b1, `OFS_FILT_BASE + 8'h04, m.id);
        acc(1'b1, `OFS_FILT_EN, 32'h1);
        acc(1'b1, `OFS_SOFT_RESET, bit_of(`SRR_ENABLE));
        exp[0] = m;
        exp[0].id = m.id ^ 32'h1;
        net.send(exp[0]);
        net.send(m);
        get(exp[0]);
        chk(exp[0], m);
        can_rx = 1'b0;
        acc(1'b0, `OFS_STATUS, '0);
        chk(v[`SR_RX_LINE], 1'b0);
        can_rx = 1'b1;
        rst_i = 1'b1;
        repeat (3) @(negedge core_clk_i);
        req = '{1'b1, 1'b0, `OFS_FILT_BASE, 32'h0};
        @(negedge core_clk_i);
        chk(ack, 1'b0);
        req.req = 1'b0;
        rst_i = 1'b0;
        repeat (3) @(negedge core_clk_i);
        acc(1'b0, `OFS_FILT_BASE + 8'h04, '0);
        chk(v, m.id);
        acc(1'b0, `OFS_SOFT_RESET, '0);
        chk(v, '0);
        test_done();
    end
endmodule : can_host_core_bench
`default_nettype wire

// file: can_host_params.svh
// offsets, field positions, clock ranges and counts of the host side of the can controller
`ifndef CAN_HOST_PARAMS_SVH
`define CAN_HOST_PARAMS_SVH

`define OFS_SOFT_RESET 8'h00
`define OFS_MODE 8'h04
`define OFS_STATUS 8'h18
`define OFS_ISR 8'h1c
`define OFS_IER 8'h20
`define OFS_ICR 8'h24
`define OFS_TXQ_ID 8'h30
`define OFS_TXQ_DLC 8'h34
`define OFS_TXQ_DW1 8'h38
`define OFS_TXQ_DW2 8'h3c
`define OFS_PB_ID 8'h40
`define OFS_PB_DLC 8'h44
`define OFS_PB_DW1 8'h48
`define OFS_PB_DW2 8'h4c
`define OFS_RXQ_ID 8'h50
`define OFS_RXQ_DLC 8'h54
`define OFS_RXQ_DW1 8'h58
`define OFS_RXQ_DW2 8'h5c
`define OFS_FILT_EN 8'h60
`define OFS_FILT_BASE 8'h64

`define SRR_SOFT_RESET 0
`define SRR_ENABLE 1
`define MSR_SLEEP 0
`define MSR_LOOPBACK 1
`define SR_FILTER_BUSY 0
`define SR_TXQ_FULL 1
`define SR_PB_FULL 2
`define SR_LOOPBACK 3
`define SR_SLEEP 4
`define SR_RX_LINE 5

`define ISR_W 6
`define ISR_TX_DONE 0
`define ISR_TXQ_FULL 1
`define ISR_PB_FULL 2
`define ISR_RX_DONE 3
`define ISR_RX_NOT_EMPTY 4
`define ISR_RX_UNDERFLOW 5

`define NUM_FILTERS 4
`define QUEUE_DEPTH 16
`define QUEUE_CNT_W 5
`define FILTER_BUSY_CYCLES 2'h2
`define CORE_CLK_MHZ 200
`define PROTOCOL_CLK_MIN_MHZ 8
`define PROTOCOL_CLK_MAX_MHZ 24
`define HOST_CLK_MIN_MHZ 8
`define HOST_CLK_MAX_MHZ 100

`endif

// file: can_net_model.sv
// network side model: acks sent frames after a random stall, offers received frames
`timescale 1ns/1ps
`default_nettype none
module can_net_model (
    input wire logic core_clk_i,
    input wire can_pkg::msg_t tx_frame_i,
    input wire logic tx_valid_i,
    output logic tx_done_o,
    output var can_pkg::msg_t rx_frame_o,
    output logic rx_valid_o,
    input wire logic rx_ready_i
);
    can_pkg::msg_t sent[$];
    initial begin
        tx_done_o = 1'b0;
        rx_valid_o = 1'b0;
        rx_frame_o = '0;
        forever begin
            @(negedge core_clk_i);
            if (tx_valid_i) begin
                repeat ($urandom_range(7)) @(negedge core_clk_i);
                sent.push_back(tx_frame_i);
                tx_done_o = 1'b1;
                @(negedge core_clk_i);
                tx_done_o = 1'b0;
            end
        end
    end
    // offer one frame, hold until taken, then scramble the released lines
    task automatic send(input can_pkg::msg_t m);
        @(negedge core_clk_i);
        rx_frame_o = m;
        rx_valid_o = 1'b1;
        while (!rx_ready_i) @(negedge core_clk_i);
        @(negedge core_clk_i);
        rx_valid_o = 1'b0;
        rx_frame_o = ~m;
    endtask : send
endmodule : can_net_model
`default_nettype wire

// file: can_pkg.sv
// types shared by the can host-side core, its bench and the network model
package can_pkg;

    typedef struct packed {
        logic [31:0] id;
        logic [31:0] dlc;
        logic [31:0] dw1;
        logic [31:0] dw2;
    } msg_t;

    typedef struct packed {
        logic req;
        logic we;
        logic [7:0] addr;
        logic [31:0] wdata;
    } reg_req_t;

    typedef enum logic [0:0] {
        TX_IDLE,
        TX_SEND
    } tx_state_t;

endpackage : can_pkg

// file: msg_queue.sv
// message fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module msg_queue #(
    parameter int WIDTH = 128,
    parameter int DEPTH = 16,
    parameter int CNT_W = $clog2(DEPTH + 1)
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    output logic [CNT_W-1:0] count_o
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] wr_ptr_q;
    logic [PW-1:0] rd_ptr_q;
    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;
    logic ready_q;
    logic valid_q;
    logic push;
    logic pop;

    assign push = in_valid_i & ready_q;
    assign pop = out_ready_i & valid_q;

    always_comb begin
        count_d = count_q + CNT_W'(push) - CNT_W'(pop);
    end

    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
            ready_q <= 1'b1;
            valid_q <= 1'b0;
        end else begin
            wr_ptr_q <= wr_ptr_q + PW'(push);
            rd_ptr_q <= rd_ptr_q + PW'(pop);
            count_q <= count_d;
            ready_q <= count_d != CNT_W'(DEPTH);
            valid_q <= count_d != '0;
        end
    end

    assign in_ready_o = ready_q;
    assign out_valid_o = valid_q;
    assign out_data_o = mem_q[rd_ptr_q];
    assign count_o = count_q;

endmodule : msg_queue

`default_nettype wire
